// *** src/bms_sentence_handler.sv ***
// Purpose: Sentence handler for pin status, login, passwords, zeroing,
//          unit reset and reset history of a battery monitor
// Assumes: Bytes arrive already framed; the transport adds the checksum
// Notes:   Each reply ends with the comma before the checksum field
`timescale 1ns/1ps
`default_nettype none

module bms_sentence_handler #(
    parameter int TICK_CYC = bms_sentence_pkg::TICK_CYC
) (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // Wishbone slave
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [7:0]                wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    // Received sentence bytes
    input  wire logic [7:0]                rx_data_i,
    input  wire logic                      rx_valid_i,
    output logic                           rx_ready_o,
    // Transmitted sentence bytes
    output logic      [7:0]                tx_data_o,
    output logic                           tx_valid_o,
    output logic                           tx_last_o,
    input  wire logic                      tx_ready_i,
    // Output pin levels
    input  wire bms_sentence_pkg::pins_s   pins_i,
    // Reset source logging
    input  wire logic [31:0]               seconds_i,
    input  wire logic                      rst_event_i,
    input  wire logic [6:0]                rst_flags_i,
    // Actions
    output logic                           zero_current_o,
    output logic                           unit_reset_o
);

    localparam int TW = $clog2(TICK_CYC);

    // ************************************************************
    // Pin synchroniser
    // ************************************************************
    logic [4:0]                pin_s1_reg;
    logic [4:0]                pin_s2_reg;
    logic [4:0]                pin_s3_reg;
    bms_sentence_pkg::pins_s   pin_reg;
    wire  [4:0]                pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
    wire  [4:0]                pin_next  = (pin_s2_reg & pin_agree)
                                         | (pin_reg & ~pin_agree);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_s1_reg <= 5'h00;
            pin_s2_reg <= 5'h00;
            pin_s3_reg <= 5'h00;
            pin_reg    <= '0;
        end
        else
        begin
            pin_s1_reg <= pins_i;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_reg    <= pin_next;
        end
    end

    // ************************************************************
    // Wishbone registers
    // ************************************************************
    logic [1:0]  ctrl_reg;
    logic [15:0] per_act_reg;
    logic [15:0] per_slp_reg;
    logic        ack_reg;
    logic [31:0] dat_reg;
    logic [1:0]  level_reg;
    logic [3:0]  pw1_len_reg;
    logic [3:0]  pw2_len_reg;
    logic [6:0]  rem_reg;
    logic        cmd_pend_reg;
    logic        ot_due_reg;

    wire        wb_hit = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire        wb_wr  = wb_hit & wb_we_i;
    wire [31:0] wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire        wr_ctrl = wb_wr & (wb_adr_i == bms_sentence_pkg::ADR_CTRL);
    wire        wr_act  = wb_wr & (wb_adr_i == bms_sentence_pkg::ADR_PER_ACT);
    wire        wr_slp  = wb_wr & (wb_adr_i == bms_sentence_pkg::ADR_PER_SLP);
    wire [31:0] ctrl_m  = ({30'h0, ctrl_reg} & ~wmask) | (wb_dat_i & wmask);
    wire [31:0] act_m   = ({16'h0, per_act_reg} & ~wmask) | (wb_dat_i & wmask);
    wire [31:0] slp_m   = ({16'h0, per_slp_reg} & ~wmask) | (wb_dat_i & wmask);
    wire [31:0] status  = {19'h0, ot_due_reg, cmd_pend_reg, rem_reg != 7'h00,
                           pw2_len_reg != 4'h0, pw1_len_reg != 4'h0,
                           6'h00, level_reg};
    wire [31:0] rd_data =
        (wb_adr_i == bms_sentence_pkg::ADR_CTRL)    ? {30'h0, ctrl_reg} :
        (wb_adr_i == bms_sentence_pkg::ADR_PER_ACT) ? {16'h0, per_act_reg} :
        (wb_adr_i == bms_sentence_pkg::ADR_PER_SLP) ? {16'h0, per_slp_reg} :
        (wb_adr_i == bms_sentence_pkg::ADR_STATUS)  ? status : 32'h0000_0000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg    <= bms_sentence_pkg::CTRL_RST;
            per_act_reg <= bms_sentence_pkg::PER_ACT_RST;
            per_slp_reg <= bms_sentence_pkg::PER_SLP_RST;
            ack_reg     <= 1'b0;
            dat_reg     <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= wb_hit;
            dat_reg <= rd_data;
            if (wr_ctrl)
                ctrl_reg <= ctrl_m[1:0];
            if (wr_act)
                per_act_reg <= act_m[15:0];
            if (wr_slp)
                per_slp_reg <= slp_m[15:0];
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // ************************************************************
    // Millisecond tick and status period
    // ************************************************************
    logic [TW-1:0] tick_cnt_reg;
    logic [15:0]   per_cnt_reg;
    logic          ot_start;

    wire        tick    = tick_cnt_reg == TW'(TICK_CYC - 1);
    wire [15:0] per_sel = ctrl_reg[bms_sentence_pkg::CTRL_SLEEP] ? per_slp_reg
                                                                : per_act_reg;
    wire        expire  = tick & (per_sel != 16'h0000)
                        & (per_cnt_reg >= 16'(per_sel - 16'h0001));

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tick_cnt_reg <= '0;
            per_cnt_reg  <= 16'h0000;
            ot_due_reg   <= 1'b0;
        end
        else
        begin
            tick_cnt_reg <= tick ? '0 : TW'(tick_cnt_reg + 1'b1);
            if (tick)
                per_cnt_reg <= expire ? 16'h0000 : 16'(per_cnt_reg + 16'h0001);
            ot_due_reg <= expire | (ot_due_reg & ~ot_start);
        end
    end

    // ************************************************************
    // Sentence receiver
    // ************************************************************
    bms_sentence_pkg::rx_state_e rx_state_reg;
    logic [23:0] id_reg;
    logic [63:0] par_reg;
    logic [3:0]  plen_reg;
    logic        rx_ready_reg;
    logic        go;

    wire take   = rx_valid_i & rx_ready_reg;
    wire is_lf  = rx_data_i == bms_sentence_pkg::CH_LF;
    wire is_cr  = rx_data_i == bms_sentence_pkg::CH_CR;
    wire is_cma = rx_data_i == bms_sentence_pkg::CH_COMMA;
    wire pend_next = (cmd_pend_reg & ~go) | (take & is_lf);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_state_reg <= bms_sentence_pkg::RX_ID;
            id_reg       <= 24'h00_0000;
            par_reg      <= 64'h0000_0000_0000_0000;
            plen_reg     <= 4'h0;
            cmd_pend_reg <= 1'b0;
            rx_ready_reg <= 1'b0;
        end
        else
        begin
            cmd_pend_reg <= pend_next;
            rx_ready_reg <= ~pend_next;
            if (go)
            begin
                id_reg   <= 24'h00_0000;
                par_reg  <= 64'h0000_0000_0000_0000;
                plen_reg <= 4'h0;
            end
            if (take & is_lf)
                rx_state_reg <= bms_sentence_pkg::RX_ID;
            else if (take & ~is_cr)
            begin
                unique case (rx_state_reg)
                    bms_sentence_pkg::RX_ID:
                        if (is_cma)
                            rx_state_reg <= bms_sentence_pkg::RX_PARAM;
                        else
                            id_reg <= {id_reg[15:0], rx_data_i};
                    bms_sentence_pkg::RX_PARAM:
                        if (is_cma)
                            rx_state_reg <= bms_sentence_pkg::RX_SKIP;
                        else if (plen_reg != bms_sentence_pkg::PLEN_OVF)
                        begin
                            par_reg  <= {par_reg[55:0], rx_data_i};
                            plen_reg <= plen_reg + 4'h1;
                        end
                    bms_sentence_pkg::RX_SKIP:
                        rx_state_reg <= bms_sentence_pkg::RX_SKIP;
                    default:
                        rx_state_reg <= bms_sentence_pkg::RX_ID;
                endcase
            end
        end
    end

    assign rx_ready_o = rx_ready_reg;

    // ************************************************************
    // Command decode and access level
    // ************************************************************
    logic [63:0] pw1_reg;
    logic [63:0] pw2_reg;
    logic        user_pend_reg;

    wire tx_idle = rem_reg == 7'h00;
    assign go    = cmd_pend_reg & tx_idle;
    wire empty   = plen_reg == 4'h0;
    wire is_q    = (plen_reg == 4'h1)
                 & (par_reg[7:0] == bms_sentence_pkg::CH_QUEST);
    wire c_ot    = go & (id_reg == bms_sentence_pkg::ID_OT);
    wire c_pw1   = go & (id_reg == bms_sentence_pkg::ID_PW1);
    wire c_pw2   = go & (id_reg == bms_sentence_pkg::ID_PW2);
    wire c_rc    = go & (id_reg == bms_sentence_pkg::ID_RC) & empty;
    wire c_rs    = go & (id_reg == bms_sentence_pkg::ID_RS) & empty;
    wire c_rs2   = go & (id_reg == bms_sentence_pkg::ID_RS2) & is_q;
    wire deny    = ctrl_reg[bms_sentence_pkg::CTRL_LOCK] & (level_reg == 2'd0);
    // A cleared password leaves its level open to any login
    wire match1  = (pw1_len_reg == 4'h0)
                 | ((pw1_len_reg == plen_reg) & (pw1_reg == par_reg));
    wire match2  = (pw2_len_reg == 4'h0)
                 | ((pw2_len_reg == plen_reg) & (pw2_reg == par_reg));
    wire up      = ((level_reg == 2'd0) & match1)
                 | ((level_reg == 2'd1) & match2);
    wire [1:0] lvl_dn = (level_reg == 2'd0) ? 2'd0 : level_reg - 2'd1;
    wire [1:0] level_next =
        ~c_pw1 | is_q ? level_reg :
        empty         ? lvl_dn :
        up            ? level_reg + 2'd1 : level_reg;
    wire len_ok  = (plen_reg >= bms_sentence_pkg::PW_MIN)
                 & (plen_reg <= bms_sentence_pkg::PW_MAX);
    wire pw_ok   = (level_reg != 2'd0) & (empty | len_ok);
    wire wr_pw1  = c_pw2 & pw_ok & (level_reg == 2'd1);
    wire wr_pw2  = c_pw2 & pw_ok & (level_reg == 2'd2);
    wire do_zero = c_rc & ~deny;
    wire do_rst  = c_rs & ~deny;
    wire r_ask   = (c_rc | c_rs) & deny;
    wire r_ot    = (c_ot & is_q) | (~cmd_pend_reg & ot_due_reg & tx_idle);
    assign ot_start = r_ot;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            level_reg      <= 2'd0;
            pw1_reg        <= 64'h0000_0000_0000_0000;
            pw2_reg        <= 64'h0000_0000_0000_0000;
            pw1_len_reg    <= 4'h0;
            pw2_len_reg    <= 4'h0;
            zero_current_o <= 1'b0;
            unit_reset_o   <= 1'b0;
        end
        else
        begin
            level_reg      <= level_next;
            zero_current_o <= do_zero;
            unit_reset_o   <= do_rst;
            if (wr_pw1)
            begin
                pw1_reg     <= par_reg;
                pw1_len_reg <= plen_reg;
            end
            if (wr_pw2)
            begin
                pw2_reg     <= par_reg;
                pw2_len_reg <= plen_reg;
            end
        end
    end

    // ************************************************************
    // Reset history
    // ************************************************************
    bms_sentence_pkg::hist_rec_s hist_reg [bms_sentence_pkg::HIST_RECS];
    wire [6:0] new_flags = rst_flags_i
                         | (7'(user_pend_reg) << bms_sentence_pkg::USER_FLAG);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            user_pend_reg <= 1'b0;
            for (int i = 0; i < bms_sentence_pkg::HIST_RECS; i++)
                hist_reg[i] <= '0;
        end
        else
        begin
            user_pend_reg <= do_rst | (user_pend_reg & ~rst_event_i);
            if (rst_event_i)
            begin
                hist_reg[0] <= {seconds_i, new_flags};
                for (int i = 1; i < bms_sentence_pkg::HIST_RECS; i++)
                    hist_reg[i] <= hist_reg[i-1];
            end
        end
    end

    // ************************************************************
    // Reply lines
    // ************************************************************
    wire [7:0] cma  = bms_sentence_pkg::CH_COMMA;
    wire [7:0] zero = bms_sentence_pkg::CH_ZERO;
    wire [3:0] f3hi = {pin_reg.ind, pin_reg.buzz, pin_reg.low, pin_reg.heat};
    wire [127:0] ot_line = {bms_sentence_pkg::ID_OT, cma,
        bms_sentence_pkg::hex_char({pin_reg.chg, 3'h0}), zero,
        cma, zero, zero, cma,
        bms_sentence_pkg::hex_char(f3hi), zero,
        cma, zero, zero, cma};
    wire [7:0] auth_ch = r_ask ? bms_sentence_pkg::CH_QUEST
                               : zero + {6'h00, level_next};
    wire [47:0] auth_line = {bms_sentence_pkg::ID_PW1, cma, auth_ch, cma};
    wire [47:0] pwr_line  = {bms_sentence_pkg::ID_PW2, cma,
                             zero + {7'h00, pw_ok}, cma};
    wire [479:0] rs2_body;

    genvar r;
    generate
        for (r = 0; r < bms_sentence_pkg::HIST_RECS; r++)
        begin : g_rec
            wire [31:0] ts = hist_reg[r].ts;
            wire [7:0]  fl = {1'b0, hist_reg[r].flags};
            assign rs2_body[(4-r)*96 +: 96] = {cma,
                bms_sentence_pkg::hex_char(ts[31:28]),
                bms_sentence_pkg::hex_char(ts[27:24]),
                bms_sentence_pkg::hex_char(ts[23:20]),
                bms_sentence_pkg::hex_char(ts[19:16]),
                bms_sentence_pkg::hex_char(ts[15:12]),
                bms_sentence_pkg::hex_char(ts[11:8]),
                bms_sentence_pkg::hex_char(ts[7:4]),
                bms_sentence_pkg::hex_char(ts[3:0]),
                cma,
                bms_sentence_pkg::hex_char(fl[7:4]),
                bms_sentence_pkg::hex_char(fl[3:0])};
        end
    endgenerate

    wire [511:0] rs2_line = {bms_sentence_pkg::ID_RS2, rs2_body, cma};
    wire r_short = c_pw1 | c_pw2 | r_ask;
    wire send    = r_ot | c_rs2 | r_short;
    wire [511:0] new_line =
        r_ot  ? {ot_line, 384'h0} :
        c_rs2 ? rs2_line :
        c_pw2 ? {pwr_line, 464'h0} : {auth_line, 464'h0};
    wire [6:0] new_len =
        r_ot  ? bms_sentence_pkg::LEN_OT :
        c_rs2 ? bms_sentence_pkg::LEN_RS2 : bms_sentence_pkg::LEN_SHORT;

    // ************************************************************
    // Byte transmitter
    // ************************************************************
    logic [511:0] line_reg;
    wire          adv = ~tx_valid_o | tx_ready_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            line_reg   <= '0;
            rem_reg    <= 7'h00;
            tx_data_o  <= 8'h00;
            tx_valid_o <= 1'b0;
            tx_last_o  <= 1'b0;
        end
        else if (tx_idle)
        begin
            if (send)
            begin
                line_reg <= new_line;
                rem_reg  <= new_len;
            end
            if (adv)
                tx_valid_o <= 1'b0;
        end
        else if (adv)
        begin
            tx_data_o  <= line_reg[511:504];
            tx_valid_o <= 1'b1;
            tx_last_o  <= rem_reg == 7'h01;
            line_reg   <= {line_reg[503:0], 8'h00};
            rem_reg    <= rem_reg - 7'h01;
        end
    end

endmodule

`default_nettype wire

// *** src/bms_sentence_pkg.sv ***
// Purpose: Shared constants and types of the battery monitor sentence handler
// Assumes: 250 MHz clock, 32-bit classic Wishbone register port
// Notes:   Sentence identifiers and characters are plain ASCII codes
package bms_sentence_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0]  ADR_CTRL    = 8'h00;
    localparam logic [7:0]  ADR_PER_ACT = 8'h04;
    localparam logic [7:0]  ADR_PER_SLP = 8'h08;
    localparam logic [7:0]  ADR_STATUS  = 8'h0c;
    localparam int          CTRL_SLEEP  = 0;
    localparam int          CTRL_LOCK   = 1;
    localparam logic [1:0]  CTRL_RST    = 2'h0;
    localparam logic [15:0] PER_ACT_RST = 16'h03e8;
    localparam logic [15:0] PER_SLP_RST = 16'h2710;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ   = 250_000_000;
    localparam int TICK_MS  = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;

    // ************************************************************
    // Sentence bytes
    // ************************************************************
    localparam logic [23:0] ID_OT   = 24'h4f_5431;
    localparam logic [23:0] ID_PW1  = 24'h50_5731;
    localparam logic [23:0] ID_PW2  = 24'h50_5732;
    localparam logic [23:0] ID_RC   = 24'h52_4331;
    localparam logic [23:0] ID_RS   = 24'h52_5331;
    localparam logic [23:0] ID_RS2  = 24'h52_5332;
    localparam logic [7:0]  CH_COMMA = 8'h2c;
    localparam logic [7:0]  CH_QUEST = 8'h3f;
    localparam logic [7:0]  CH_LF    = 8'h0a;
    localparam logic [7:0]  CH_CR    = 8'h0d;
    localparam logic [7:0]  CH_ZERO  = 8'h30;
    localparam logic [7:0]  CH_ALPHA = 8'h37;
    localparam logic [3:0]  PW_MAX   = 4'h8;
    localparam logic [3:0]  PW_MIN   = 4'h4;
    localparam logic [3:0]  PLEN_OVF = 4'h9;
    localparam int          HIST_RECS = 5;
    localparam int          USER_FLAG = 6;
    localparam logic [6:0]  LEN_OT    = 7'h10;
    localparam logic [6:0]  LEN_SHORT = 7'h06;
    localparam logic [6:0]  LEN_RS2   = 7'h40;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic chg;
        logic ind;
        logic buzz;
        logic low;
        logic heat;
    } pins_s;

    typedef struct packed {
        logic [31:0] ts;
        logic [6:0]  flags;
    } hist_rec_s;

    typedef enum logic [2:0] {
        RX_ID    = 3'b001,
        RX_PARAM = 3'b010,
        RX_SKIP  = 3'b100
    } rx_state_e;

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        hex_char = (n < 4'ha) ? CH_ZERO + {4'h0, n} : CH_ALPHA + {4'h0, n};
    endfunction

endpackage

// *** verification/bms_sentence_handler_assertions.sv ***
// Purpose: Port checks of the sentence handler
// Assumes: One clock, reset active high
// Notes:   Bound into every handler instance
`timescale 1ns/1ps
`default_nettype none
module bms_handler_checker (
    // Watched ports
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic [7:0] rx_data_i,
    input wire logic       rx_valid_i,
    input wire logic       rx_ready_o,
    input wire logic [7:0] tx_data_o,
    input wire logic       tx_valid_o,
    input wire logic       tx_last_o,
    input wire logic       tx_ready_i,
    input wire logic       zero_current_o,
    input wire logic       unit_reset_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_DUE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack late");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack too long");
    AST_RX_HOLD: assert property (
        rx_valid_i && rx_ready_o && rx_data_i == bms_sentence_pkg::CH_LF |=> !rx_ready_o)
        else $error("byte taken after line end");
    AST_TX_STABLE: assert property (
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
        else $error("tx byte not held");
    AST_TX_ASCII: assert property (tx_valid_o |-> tx_data_o inside {[8'h20:8'h7e]})
        else $error("tx byte not text");
    AST_TX_END: assert property (
        tx_valid_o && tx_last_o |-> tx_data_o == bms_sentence_pkg::CH_COMMA)
        else $error("sentence not ended by comma");
    AST_TX_HEAD: assert property (
        tx_valid_o && tx_ready_i && tx_last_o |=> !tx_valid_o || tx_data_o inside {[8'h41:8'h5a]})
        else $error("sentence head not a letter");
    AST_ZERO_ONE: assert property (zero_current_o |=> !zero_current_o)
        else $error("zero pulse too long");
    AST_UNIT_ONE: assert property (unit_reset_o |=> !unit_reset_o)
        else $error("reset pulse too long");
endmodule
bind bms_sentence_handler bms_handler_checker chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .rx_data_i, .rx_valid_i, .rx_ready_o, .tx_data_o, .tx_valid_o, .tx_last_o,
    .tx_ready_i, .zero_current_o, .unit_reset_o);
`default_nettype wire

// *** verification/host_model.sv ***
// Purpose: Host side of the sentence link
// Assumes: One byte per handshake
// Notes:   Reply bytes gather into line
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Link
    input  wire logic       clk_i,
    output logic      [7:0] rx_data_o,
    output logic            rx_valid_o,
    input  wire logic       rx_ready_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    input  wire logic       tx_last_i,
    output logic            tx_ready_o
);
    string line = "";
    int    cnt  = 0;
    bit    slow = 0;
    initial
    begin
        rx_data_o  = 8'h00;
        rx_valid_o = 1'b0;
        tx_ready_o = 1'b1;
    end
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++)
        begin
            rx_data_o  <= s[i];
            rx_valid_o <= 1'b1;
            @(posedge clk_i);
            while (!rx_ready_i)
                @(posedge clk_i);
        end
        rx_data_o  <= ~rx_data_o;
        rx_valid_o <= 1'b0;
    endtask
    always @(posedge clk_i)
    begin
        if (tx_valid_i && tx_ready_o)
        begin
            line = $sformatf("%s%c", line, tx_data_i);
            cnt  += tx_last_i;
        end
        tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
    end
endmodule
`default_nettype wire

// *** verification/battery_monitor_sentence_handler_tb.sv ***
// Purpose: Self-checking bench of the sentence handler
// Assumes: Host model drives the sentence link
// Notes:   Short tick keeps periods brief
`timescale 1ns/1ps
`default_nettype none
module battery_monitor_sentence_handler_tb;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 8'h00, rx_data_i, tx_data_o;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q, seconds_i = 32'h0000_0000;
    logic wb_ack_o, rx_valid_i, rx_ready_o, tx_valid_o, tx_last_o, tx_ready_i;
    logic zero_current_o, unit_reset_o, rst_event_i = 0;
    logic [6:0] rst_flags_i = 7'h00;
    bms_sentence_pkg::pins_s pins_i = '0;
    int failures = 0, comparisons = 0, zeros = 0, resets = 0;
    bms_sentence_handler #(.TICK_CYC(8)) bms_sentence_handler_inst (.clk_i, .rst_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .rx_data_i, .rx_valid_i, .rx_ready_o, .tx_data_o, .tx_valid_o, .tx_last_o,
        .tx_ready_i, .pins_i, .seconds_i, .rst_event_i, .rst_flags_i, .zero_current_o,
        .unit_reset_o);
    host_model host_model_inst (.clk_i, .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i),
        .rx_ready_i(rx_ready_o), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
        .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i));
    initial forever #2 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        zeros  += (zero_current_o !== 1'b0);
        resets += (unit_reset_o !== 1'b0);
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic cmd(input string s, input string e);
        host_model_inst.line = "";
        host_model_inst.cnt  = 0;
        host_model_inst.send(s);
        for (int n = 0; n < 900 && host_model_inst.cnt == 0; n++)
            @(posedge clk_i);
        comparisons++;
        if (host_model_inst.line != e)
        begin
            failures++;
            $display("BAD reply expected %s seen %s", e, host_model_inst.line);
        end
    endtask
    task automatic pulse_wait(ref int c);
        for (int n = 0; n < 60 && c == 0; n++)
            @(posedge clk_i);
    endtask
    task automatic log_reset(input logic [31:0] s, input logic [6:0] f);
        seconds_i   <= s;
        rst_flags_i <= f;
        rst_event_i <= 1'b1;
        @(posedge clk_i);
        rst_event_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic conclude();
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, bms_sentence_pkg::ADR_PER_ACT, 0);
        chk("act_period", 32'h0000_03e8, q);
        wb(0, bms_sentence_pkg::ADR_PER_SLP, 0);
        chk("sleep_period", 32'h0000_2710, q);
        wb(1, bms_sentence_pkg::ADR_PER_ACT, 0);
        wb(0, bms_sentence_pkg::ADR_PER_ACT, 0);
        chk("act_written", 32'h0000_0000, q);
        wb(0, 8'h10, 0);
        chk("unmapped", 32'h0000_0000, q);
        pins_i <= 5'b11010;
        cmd("OT1,?,00\n", "OT1,80,00,A0,00,");
        pins_i <= 5'b00101;
        host_model_inst.slow = 1;
        cmd("OT1,?,00\n", "OT1,00,00,50,00,");
        host_model_inst.slow = 0;
        cmd("PW1,?,00\n", "PW1,0,");
        cmd("PW2,abcd,00\n", "PW2,0,");
        cmd("PW1,abcd,00\n", "PW1,1,");
        cmd("PW2,ab,00\n", "PW2,0,");
        cmd("PW2,pass1234,00\n", "PW2,1,");
        cmd("PW1,,00\n", "PW1,0,");
        cmd("PW1,wrong,00\n", "PW1,0,");
        cmd("PW1,pass1234,00\n", "PW1,1,");
        cmd("PW1,?,00\n", "PW1,1,");
        cmd("PW1,any,00\n", "PW1,2,");
        cmd("PW2,lvl2pass,00\n", "PW2,1,");
        wb(0, bms_sentence_pkg::ADR_STATUS, 0);
        chk("status_set", 32'h0000_0302, q);
        cmd("PW2,,00\n", "PW2,1,");
        wb(0, bms_sentence_pkg::ADR_STATUS, 0);
        chk("status_clr", 32'h0000_0102, q);
        cmd("PW1,,00\n", "PW1,1,");
        cmd("PW1,,00\n", "PW1,0,");
        wb(1, bms_sentence_pkg::ADR_CTRL, 32'h0000_0002);
        cmd("RC1,,00\n", "PW1,?,");
        chk("zero_locked", 0, zeros);
        wb(1, bms_sentence_pkg::ADR_CTRL, 0);
        host_model_inst.send("RC1,,00\n");
        pulse_wait(zeros);
        chk("zero_pulse", 1, zeros);
        host_model_inst.send("RS1,,00\n");
        pulse_wait(resets);
        chk("unit_reset", 1, resets);
        log_reset(32'h1bca_b37c, 7'h01);
        log_reset(32'h0000_0010, 7'h04);
        cmd("RS2,?,00\n",
            "RS2,00000010,04,1BCAB37C,41,00000000,00,00000000,00,00000000,00,");
        wb(1, bms_sentence_pkg::ADR_PER_ACT, 32'h0000_0002);
        cmd("", "OT1,00,00,50,00,");
        conclude();
    end
    initial
    begin
        #200000;
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
